/* rtl/tw_defines.svh */
// Register indices, field positions, reset values and count limits
`ifndef TW_DEFINES_SVH
`define TW_DEFINES_SVH

// Register indices; the byte address is four times the index
`define TW_IDX_CTRL_A    10'h0B0
`define TW_IDX_CTRL_B    10'h0B1
`define TW_IDX_COUNT     10'h0B2
`define TW_IDX_CMP_A     10'h0B3
`define TW_IDX_CMP_B     10'h0B4
`define TW_IDX_PORT      10'h0C0
`define TW_IDX_IRQ_STAT  10'h0C1
`define TW_IDX_IRQ_EN    10'h0C2
`define TW_IDX_IRQ_CLR   10'h0C3

// Waveform control A fields
`define TW_A_ACT_HI      7
`define TW_A_ACT_LO      6
`define TW_B_ACT_HI      5
`define TW_B_ACT_LO      4
`define TW_MODE_LOW_HI   1
`define TW_MODE_LOW_LO   0

// Waveform control B fields
`define TW_TOP_BIT       3
`define TW_CS_HI         2
`define TW_CS_LO         0

// Port register fields: direction bits 1:0, port data bits 5:4
`define TW_DIR_HI        1
`define TW_DIR_LO        0
`define TW_DATA_HI       5
`define TW_DATA_LO       4

// Interrupt status bit positions
`define TW_IRQ_OVF       0
`define TW_IRQ_MATCH_A   1
`define TW_IRQ_MATCH_B   2

// Count limits and reset values
`define TW_MAX           8'hFF
`define TW_BOTTOM        8'h00
`define TW_RST_BYTE      8'h00
`define TW_RST_ACT       2'h0
`define TW_RST_MODE      2'h0
`define TW_RST_CS        3'h0
`define TW_RST_PAIR      2'h0
`define TW_RST_IRQ       3'h0
`define TW_CS_STOP       3'h0

`endif

/* rtl/tw_pkg.sv */
// Types shared by the timer waveform output block
package tw_pkg;

  // Three-bit waveform mode, low bits from control A, top bit from control B
  typedef enum logic [2:0] {
    TW_NORMAL   = 3'b000,
    TW_PC_FF    = 3'b001,
    TW_CTC      = 3'b010,
    TW_FAST_FF  = 3'b011,
    TW_RSV4     = 3'b100,
    TW_PC_CMP   = 3'b101,
    TW_RSV6     = 3'b110,
    TW_FAST_CMP = 3'b111
  } tw_mode_e;

  // Per-channel compare configuration
  typedef struct packed {
    logic [1:0] act;
    logic [7:0] cmp_buf;
    logic [7:0] cmp_act;
  } tw_chan_s;

  // Result of one channel's waveform step
  typedef struct packed {
    logic conn;
    logic lvl;
  } tw_wave_s;

endpackage : tw_pkg

/* rtl/tw_waveform.sv */
// Eight-bit timer with two compare channels and waveform outputs
//
// Behaviour
// (R1) A channel whose action field is nonzero, except the disconnected 01 cases of R5, R10 and R11, drives its waveform on the pin instead of port data.
// (R2) The pin driver is enabled only while that pin's direction bit selects output.
// (R3) In normal or clear-on-match mode channel A disconnects, toggles, clears or sets on match for 00, 01, 10, 11.
// (R4) In fast PWM channel A action 10 clears on match and sets at bottom, action 11 does the reverse.
// (R5) In either PWM mode channel A action 01 is disconnected when the top mode bit is 0 and toggles on match when it is 1.
// (R6) In fast PWM a compare value equal to the ceiling with the high action bit set ignores the match and acts at bottom.
// (R7) In phase-correct PWM channel A action 10 clears on up-count match and sets on down-count match, 11 the reverse.
// (R8) In phase-correct PWM a compare value equal to the ceiling with the high action bit set ignores the match and acts at the ceiling.
// (R9) In normal or clear-on-match mode channel B disconnects, toggles, clears or sets on match for 00, 01, 10, 11.
// (R10) In fast PWM channel B action 01 is reserved, 10 clears on match and sets at bottom, 11 the reverse.
// (R11) In phase-correct PWM channel B action 01 is reserved, 10 clears on up match and sets on down match, 11 the reverse.
// (R12) Bits 3:2 of control A always read as zero.
// (R13) The waveform mode is the control A low bits 1:0 joined with the top mode bit of control B.
// (R14) Modes are 0 normal, 1 and 5 phase-correct, 2 clear-on-match, 3 and 7 fast PWM, 4 and 6 reserved.
// (R15) The ceiling is 0xFF in modes 0, 1 and 3 and the channel A compare value in modes 2, 5 and 7.
// (R16) Compare values load at once in non-PWM modes, at the ceiling in phase-correct and at bottom in fast PWM.
// (R17) The overflow flag sets at 0xFF in modes 0, 2 and 3, at bottom in modes 1 and 5, and at the ceiling in mode 7.

`include "tw_defines.svh"

module tw_waveform
  import tw_pkg::*;
#(
  parameter int ADR_W = 12
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             tick_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  chan_a_wave_pin_o,
  output logic                  chan_a_wave_pin_oe_o,
  output logic                  chan_b_wave_pin_o,
  output logic                  chan_b_wave_pin_oe_o,
  output logic                  irq_o
);

  // Word index decode needs all index bits present
  if (ADR_W < 12) begin : g_adr_check
    $error("tw_waveform: ADR_W must be at least 12");
  end

  tw_chan_s   chan_q [2];
  logic [1:0] wave_mode_low_q;
  logic       wave_mode_top_bit_q;
  logic [2:0] clk_sel_q;
  logic [7:0] count_q;
  logic       up_q;
  logic       skip_q;
  logic [1:0] port_dir_q;
  logic [1:0] port_data_q;
  logic [1:0] wave_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_en_q;
  logic       ack_q;
  logic [31:0] dat_q;
  logic [1:0] pin_q;
  logic [1:0] pin_oe_q;
  logic       irq_q;

  tw_mode_e   wave_mode;
  logic       is_fast;
  logic       is_pc;
  logic       top_is_cmp;
  logic [7:0] top_val;
  logic       tick;
  logic       at_top;
  logic       top_ev;
  logic       ovf_ev;
  logic       cmp_load;
  logic [1:0] match;
  logic [1:0] cmp_eq_top;
  tw_wave_s   wave_d [2];
  logic       req;
  logic       wr;
  logic [9:0] idx;
  logic [2:0] irq_stat_d;

  // Mode decode, ceiling and event strobes
  always_comb begin
    wave_mode  = tw_mode_e'({wave_mode_top_bit_q, wave_mode_low_q}); // R13
    is_fast    = (wave_mode == TW_FAST_FF) || (wave_mode == TW_FAST_CMP); // R14
    is_pc      = (wave_mode == TW_PC_FF) || (wave_mode == TW_PC_CMP);
    top_is_cmp = (wave_mode == TW_CTC) || (wave_mode == TW_PC_CMP) ||
                 (wave_mode == TW_FAST_CMP);
    top_val    = top_is_cmp ? chan_q[0].cmp_act : `TW_MAX; // R15
    tick       = tick_i && (clk_sel_q != `TW_CS_STOP);
    at_top     = (count_q == top_val);
    top_ev     = tick && at_top;
    // Overflow point depends on mode
    if (is_pc) begin
      ovf_ev = tick && (count_q == `TW_BOTTOM); // R17
    end else if (wave_mode == TW_FAST_CMP) begin
      ovf_ev = top_ev; // R17
    end else begin
      ovf_ev = tick && (count_q == `TW_MAX); // R17
    end
    // Fast PWM wraps to bottom on the same tick that sees the ceiling
    cmp_load = (is_fast || is_pc) ? top_ev : 1'b1; // R16
    for (int c = 0; c < 2; c++) begin
      match[c]      = tick && !skip_q && (count_q == chan_q[c].cmp_act);
      cmp_eq_top[c] = (chan_q[c].cmp_act == top_val);
    end
  end

  // One waveform step for one channel
  function automatic tw_wave_s f_wave(
    input logic [1:0] act,
    input logic       is_a,
    input logic       topb,
    input logic       fast,
    input logic       pc,
    input logic       hit,
    input logic       ceil_ev,
    input logic       up,
    input logic       eq_top,
    input logic       cur
  );
    tw_wave_s w;
    w.conn = 1'b0;
    w.lvl  = cur;
    if (!fast && !pc) begin
      w.conn = (act != 2'b00); // R1 R3 R9
      if (hit) begin
        unique case (act)
          2'b00: w.lvl = cur;
          2'b01: w.lvl = ~cur; // R3 R9
          2'b10: w.lvl = 1'b0;
          2'b11: w.lvl = 1'b1;
        endcase
      end
    end else if (act == 2'b01) begin
      // Channel B leaves the reserved code disconnected
      w.conn = is_a && topb; // R5 R10 R11
      if (w.conn && hit) begin
        w.lvl = ~cur; // R5
      end
    end else if (act[1]) begin
      w.conn = 1'b1;
      if (fast) begin
        if (ceil_ev) begin
          w.lvl = ~act[0]; // R4 R6 R10
        end else if (hit && !eq_top) begin
          w.lvl = act[0]; // R4 R10
        end
      end else if (eq_top) begin
        // Ceiling behaves as an up-count match to keep symmetry
        if (ceil_ev) begin
          w.lvl = act[0]; // R8
        end
      end else if (hit) begin
        w.lvl = up ? act[0] : ~act[0]; // R7 R11
      end
    end
    return w;
  endfunction

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      wave_d[c] = f_wave(chan_q[c].act, (c == 0), wave_mode_top_bit_q,
                         is_fast, is_pc, match[c], top_ev, up_q,
                         cmp_eq_top[c], wave_q[c]);
    end
  end

  // Bus decode: one wait state, every access answered
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr  = req && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[11:2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Read mux; unmapped words and reserved bits read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      dat_q <= 32'h0000_0000;
      unique case (idx)
        `TW_IDX_CTRL_A:   dat_q[7:0] <= {chan_q[0].act, chan_q[1].act,
                                         2'b00, wave_mode_low_q}; // R12
        `TW_IDX_CTRL_B:   dat_q[3:0] <= {wave_mode_top_bit_q, clk_sel_q};
        `TW_IDX_COUNT:    dat_q[7:0] <= count_q;
        `TW_IDX_CMP_A:    dat_q[7:0] <= chan_q[0].cmp_buf;
        `TW_IDX_CMP_B:    dat_q[7:0] <= chan_q[1].cmp_buf;
        `TW_IDX_PORT:     dat_q[5:0] <= {port_data_q, 2'b00, port_dir_q};
        `TW_IDX_IRQ_STAT: dat_q[2:0] <= irq_stat_q;
        `TW_IDX_IRQ_EN:   dat_q[2:0] <= irq_en_q;
        default:          dat_q <= 32'h0000_0000;
      endcase
    end
  end

  // Control registers written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_q[0].act       <= `TW_RST_ACT;
      chan_q[1].act       <= `TW_RST_ACT;
      wave_mode_low_q     <= `TW_RST_MODE;
      wave_mode_top_bit_q <= 1'b0;
      clk_sel_q           <= `TW_RST_CS;
      port_dir_q          <= `TW_RST_PAIR;
      port_data_q         <= `TW_RST_PAIR;
      irq_en_q            <= `TW_RST_IRQ;
      chan_q[0].cmp_buf   <= `TW_RST_BYTE;
      chan_q[1].cmp_buf   <= `TW_RST_BYTE;
    end else if (wr) begin
      if (idx == `TW_IDX_CTRL_A) begin
        chan_q[0].act   <= wb_dat_i[`TW_A_ACT_HI:`TW_A_ACT_LO];
        chan_q[1].act   <= wb_dat_i[`TW_B_ACT_HI:`TW_B_ACT_LO];
        wave_mode_low_q <= wb_dat_i[`TW_MODE_LOW_HI:`TW_MODE_LOW_LO]; // R13
      end
      if (idx == `TW_IDX_CTRL_B) begin
        wave_mode_top_bit_q <= wb_dat_i[`TW_TOP_BIT];
        clk_sel_q           <= wb_dat_i[`TW_CS_HI:`TW_CS_LO];
      end
      if (idx == `TW_IDX_PORT) begin
        port_dir_q  <= wb_dat_i[`TW_DIR_HI:`TW_DIR_LO];
        port_data_q <= wb_dat_i[`TW_DATA_HI:`TW_DATA_LO];
      end
      if (idx == `TW_IDX_IRQ_EN) begin
        irq_en_q <= wb_dat_i[2:0];
      end
      if (idx == `TW_IDX_CMP_A) begin
        chan_q[0].cmp_buf <= wb_dat_i[7:0];
      end
      if (idx == `TW_IDX_CMP_B) begin
        chan_q[1].cmp_buf <= wb_dat_i[7:0];
      end
    end
  end

  // Active compare values follow the buffer at the mode's load point
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_q[0].cmp_act <= `TW_RST_BYTE;
      chan_q[1].cmp_act <= `TW_RST_BYTE;
    end else if (cmp_load) begin
      chan_q[0].cmp_act <= chan_q[0].cmp_buf; // R16
      chan_q[1].cmp_act <= chan_q[1].cmp_buf; // R16
    end
  end

  // Counter; a software write blocks the match on the next tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= `TW_BOTTOM;
      up_q    <= 1'b1;
      skip_q  <= 1'b0;
    end else if (wr && (idx == `TW_IDX_COUNT)) begin
      count_q <= wb_dat_i[7:0];
      skip_q  <= 1'b1;
    end else if (tick) begin
      skip_q <= 1'b0;
      if (is_pc) begin
        if (up_q && at_top) begin
          count_q <= count_q - 8'h01;
          up_q    <= 1'b0;
        end else if (!up_q && (count_q == `TW_BOTTOM)) begin
          count_q <= count_q + 8'h01;
          up_q    <= 1'b1;
        end else begin
          count_q <= up_q ? count_q + 8'h01 : count_q - 8'h01;
        end
      end else begin
        count_q <= at_top ? `TW_BOTTOM : count_q + 8'h01; // R15
        up_q    <= 1'b1;
      end
    end
  end

  // Waveform levels and registered pin drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wave_q   <= 2'b00;
      pin_q    <= 2'b00;
      pin_oe_q <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        wave_q[c]   <= wave_d[c].lvl;
        pin_q[c]    <= wave_d[c].conn ? wave_d[c].lvl : port_data_q[c]; // R1
        pin_oe_q[c] <= port_dir_q[c]; // R2
      end
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr && (idx == `TW_IDX_IRQ_CLR)) begin
      irq_stat_d = irq_stat_d & ~wb_dat_i[2:0];
    end
    irq_stat_d[`TW_IRQ_OVF]     = irq_stat_d[`TW_IRQ_OVF] | ovf_ev; // R17
    irq_stat_d[`TW_IRQ_MATCH_A] = irq_stat_d[`TW_IRQ_MATCH_A] | match[0];
    irq_stat_d[`TW_IRQ_MATCH_B] = irq_stat_d[`TW_IRQ_MATCH_B] | match[1];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= `TW_RST_IRQ;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q      <= |(irq_stat_d & irq_en_q);
    end
  end

  assign wb_ack_o             = ack_q;
  assign wb_dat_o             = dat_q;
  assign chan_a_wave_pin_o    = pin_q[0];
  assign chan_a_wave_pin_oe_o = pin_oe_q[0];
  assign chan_b_wave_pin_o    = pin_q[1];
  assign chan_b_wave_pin_oe_o = pin_oe_q[1];
  assign irq_o                = irq_q;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_pc_ceiling_hit;
    is_pc && chan_q[0].act[1] && cmp_eq_top[0] && top_ev;
  endsequence

  sequence s_count_write_then_tick;
    (wr && idx == `TW_IDX_COUNT) ##1 tick;
  endsequence

  a_ctrl_a_read: assert property ( // R12
    (ack_q && !wb_we_i && idx == `TW_IDX_CTRL_A) |->
      (wb_dat_o[3:2] == 2'b00 && wb_dat_o[7:6] == chan_q[0].act))
    else $error("control A read shows wrong reserved or action bits");

  a_mode_low_wr: assert property ( // R13
    (wr && idx == `TW_IDX_CTRL_A) |=>
      (wave_mode[1:0] == $past(wb_dat_i[1:0])))
    else $error("mode low bits not taken from control A write");

  a_ctc_wrap: assert property ( // R15
    (wave_mode == TW_CTC && tick && count_q == chan_q[0].cmp_act &&
     !wr) |=> (count_q == `TW_BOTTOM))
    else $error("clear-on-match counter did not wrap at compare A");

  a_normal_wrap: assert property ( // R15
    (wave_mode == TW_NORMAL && tick && count_q == `TW_MAX && !wr) |=>
      (count_q == `TW_BOTTOM))
    else $error("normal counter did not wrap at 0xFF");

  a_fast_cmp_hold: assert property ( // R16
    (is_fast && !top_ev) |=> $stable(chan_q[0].cmp_act))
    else $error("fast PWM compare value loaded away from bottom");

  a_ovf_flag: assert property ( // R17
    ovf_ev |=> irq_stat_q[`TW_IRQ_OVF])
    else $error("overflow event did not set its flag");

  a_nonpwm_clear: assert property ( // R3
    (!is_fast && !is_pc && chan_q[0].act == 2'b10 && match[0]) |=>
      (!wave_q[0] ##1 (!chan_a_wave_pin_o || !chan_q[0].act[1]) [*1]))
    else $error("channel A did not clear on match");

  a_fast_noninv: assert property ( // R4
    (is_fast && chan_q[0].act == 2'b10 && top_ev) |=> wave_q[0])
    else $error("fast PWM channel A not set at bottom");

  a_pc_ceiling: assert property ( // R8
    s_pc_ceiling_hit |=> (wave_q[0] == $past(chan_q[0].act[0])))
    else $error("phase-correct ceiling action wrong");

  a_pc_up_match: assert property ( // R7
    (is_pc && chan_q[0].act == 2'b11 && !cmp_eq_top[0] && match[0] &&
     up_q) |=> wave_q[0])
    else $error("phase-correct up-count match did not set");

  a_b_reserved: assert property ( // R10
    (is_fast && chan_q[1].act == 2'b01) |=>
      (chan_b_wave_pin_o == $past(port_data_q[1])))
    else $error("reserved channel B code drove the waveform");

  a_oe_follow: assert property ( // R2
    (wr && idx == `TW_IDX_PORT) |=> ##1
      (chan_a_wave_pin_oe_o == $past(port_dir_q[0])))
    else $error("pin enable does not follow direction bit");

  a_count_skip: assert property (
    s_count_write_then_tick |-> !match[0])
    else $error("match not blocked after counter write");

endmodule : tw_waveform

/* tb/tw_waveform_test.sv */
// Self-checking bench for the timer waveform output block
`include "tw_defines.svh"

module tw_waveform_test;
  import tw_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_i;
  logic        rst_i;
  logic        tick_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        pin_a;
  logic        oe_a;
  logic        pin_b;
  logic        oe_b;
  logic        irq_o;
  int          err_total;
  int          comparisons;
  logic [7:0]  d;
  // Overflow table: mode, start count, next count, overflow expected
  logic [2:0]  tm [9] = '{3'h0, 3'h0, 3'h2, 3'h2, 3'h3, 3'h1, 3'h1, 3'h5, 3'h7};
  logic [7:0]  ts [9] = '{8'hFF, 8'h05, 8'h05, 8'hFF, 8'hFF, 8'h00, 8'hFF,
                          8'h05, 8'h05};
  logic [7:0]  tn [9] = '{8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFE,
                          8'h04, 8'h00};
  logic        tv [9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  // Non-PWM action sequence; toggles are bracketed so levels are known
  logic [1:0]  na [4] = '{2'h3, 2'h1, 2'h1, 2'h2};
  logic        nl [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  tw_waveform #(.ADR_W(12)) tw_waveform_inst (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .tick_i               (tick_i),
    .wb_cyc_i             (wb_cyc_i),
    .wb_stb_i             (wb_stb_i),
    .wb_we_i              (wb_we_i),
    .wb_adr_i             (wb_adr_i),
    .wb_sel_i             (wb_sel_i),
    .wb_dat_i             (wb_dat_i),
    .wb_dat_o             (wb_dat_o),
    .wb_ack_o             (wb_ack_o),
    .chan_a_wave_pin_o    (pin_a),
    .chan_a_wave_pin_oe_o (oe_a),
    .chan_b_wave_pin_o    (pin_b),
    .chan_b_wave_pin_oe_o (oe_b),
    .irq_o                (irq_o)
  );

  // Free-running 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  // Prints the counts and the verdict, then stops the run
  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic acc(input logic we, input logic [9:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, wd};
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    // A missing answer ends the run at the single verdict point
    if (n >= 20) begin
      err_total++;
      $display("wrong value ack expected 1 seen %b", wb_ack_o);
      test_done();
    end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    logic [7:0] unused;
    acc(1'b1, idx, wd, unused);
  endtask

  task automatic rd(input logic [9:0] idx, output logic [7:0] v);
    acc(1'b0, idx, 8'h00, v);
  endtask

  // Loads the counter, then gives n single-cycle count steps
  task automatic hit(input logic [7:0] start, input int n);
    wr(`TW_IDX_COUNT, start);
    repeat (n) begin
      @(posedge clk_i);
      tick_i <= 1'b1;
      @(posedge clk_i);
      tick_i <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
  endtask

  task automatic pins(input logic a, input logic b);
    chk("pin_a", {7'h00, pin_a}, {7'h00, a});
    chk("pin_b", {7'h00, pin_b}, {7'h00, b});
  endtask

  // Watchdog: the whole sequence needs well under this span
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    test_done();
  end

  initial begin
    clk_i = 1'b0; rst_i = 1'b1; tick_i = 1'b0; wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 12'h000;
    wb_sel_i = 4'h0; wb_dat_i = 32'h00000000;
    err_total = 0;
    comparisons = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`TW_IDX_CTRL_A, d); chk("ctrl_a reset", d, 8'h00);
    wr(`TW_IDX_CTRL_A, 8'hFF);
    rd(`TW_IDX_CTRL_A, d); chk("ctrl_a spare", d, 8'hF3);
    rd(10'h0A0, d); chk("unmapped", d, 8'h00);
    wr(`TW_IDX_CTRL_A, 8'h00);
    // Disconnected channels show port data; enables follow direction
    wr(`TW_IDX_PORT, 8'h13);
    repeat (3) @(posedge clk_i);
    pins(1'b1, 1'b0);
    chk("oe", {6'h00, oe_b, oe_a}, 8'h03);
    wr(`TW_IDX_PORT, 8'h21);
    repeat (3) @(posedge clk_i);
    pins(1'b0, 1'b1);
    chk("oe", {6'h00, oe_b, oe_a}, 8'h01);
    wr(`TW_IDX_PORT, 8'h03);
    wr(`TW_IDX_CMP_A, 8'h05);
    wr(`TW_IDX_CMP_B, 8'h05);
    wr(`TW_IDX_CTRL_B, 8'h01);
    // Normal then clear-on-match: set, toggle, toggle, clear on match
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 4; i++) begin
        wr(`TW_IDX_CTRL_A, {na[i], na[i], 2'b00, m[0], 1'b0});
        hit(8'h04, 2);
        pins(nl[i], nl[i]);
      end
    end
    // Fast PWM: match level, then the opposite level at bottom
    for (int i = 2; i < 4; i++) begin
      wr(`TW_IDX_CTRL_A, {i[1:0], i[1:0], 4'h3});
      hit(8'h04, 2);
      pins(i[0], i[0]);
      hit(8'hFF, 1);
      pins(~i[0], ~i[0]);
    end
    // Action 01 in PWM: channel A disconnected unless the top mode bit is set, channel B always
    wr(`TW_IDX_PORT, 8'h33);
    wr(`TW_IDX_CTRL_A, 8'h53);
    hit(8'h04, 2);
    pins(1'b1, 1'b1);
    wr(`TW_IDX_CTRL_B, 8'h09);
    wr(`TW_IDX_CTRL_A, 8'hD3);
    hit(8'h04, 2);
    pins(1'b0, 1'b1);
    wr(`TW_IDX_CTRL_A, 8'h53);
    hit(8'h04, 2);
    pins(1'b1, 1'b1);
    hit(8'h04, 2);
    pins(1'b0, 1'b1);
    // Phase-correct: up-count match, turn at ceiling, down-count match
    wr(`TW_IDX_CTRL_B, 8'h01);
    for (int i = 2; i < 4; i++) begin
      wr(`TW_IDX_CTRL_A, {i[1:0], i[1:0], 4'h1});
      hit(8'h00, 1);
      hit(8'h04, 2);
      pins(i[0], i[0]);
      hit(8'hFF, 1);
      hit(8'h06, 2);
      pins(~i[0], ~i[0]);
    end
    // Fast PWM buffers a new compare value until bottom
    wr(`TW_IDX_CTRL_A, 8'h83);
    hit(8'hFF, 1);
    wr(`TW_IDX_CMP_A, 8'h09);
    hit(8'h04, 2);
    chk("pin_a", {7'h00, pin_a}, 8'h00);
    hit(8'hFF, 1);
    hit(8'h04, 2);
    chk("pin_a", {7'h00, pin_a}, 8'h01);
    wr(`TW_IDX_CTRL_A, 8'h00);
    wr(`TW_IDX_CMP_A, 8'h05);
    // Ceiling and overflow point for every defined mode
    wr(`TW_IDX_IRQ_EN, 8'h01);
    for (int i = 0; i < 9; i++) begin
      wr(`TW_IDX_CTRL_B, {4'h0, tm[i][2], 3'h1});
      wr(`TW_IDX_CTRL_A, {6'h00, tm[i][1:0]});
      hit(ts[i], 1);
      rd(`TW_IDX_COUNT, d); chk("count", d, tn[i]);
      rd(`TW_IDX_IRQ_STAT, d); chk("ovf", d & 8'h01, {7'h00, tv[i]});
      chk("irq", {7'h00, irq_o}, {7'h00, tv[i]});
      wr(`TW_IDX_IRQ_CLR, 8'h07);
    end
    // Masked event, read-only status, enable, then clear
    wr(`TW_IDX_IRQ_EN, 8'h00);
    hit(8'h05, 1);
    rd(`TW_IDX_IRQ_STAT, d); chk("stat", d & 8'h01, 8'h01);
    chk("irq masked", {7'h00, irq_o}, 8'h00);
    wr(`TW_IDX_IRQ_STAT, 8'h00);
    rd(`TW_IDX_IRQ_STAT, d); chk("stat ro", d & 8'h01, 8'h01);
    wr(`TW_IDX_IRQ_EN, 8'h01);
    repeat (3) @(posedge clk_i);
    chk("irq on", {7'h00, irq_o}, 8'h01);
    wr(`TW_IDX_IRQ_CLR, 8'h01);
    rd(`TW_IDX_IRQ_STAT, d); chk("stat clr", d & 8'h01, 8'h00);
    chk("irq off", {7'h00, irq_o}, 8'h00);
    // Phase-correct with compare A at the ceiling: clear done at the turn
    wr(`TW_IDX_CTRL_B, 8'h09);
    wr(`TW_IDX_CTRL_A, 8'h81);
    hit(8'h05, 1);
    chk("pin_a ceiling", {7'h00, pin_a}, 8'h00);
    test_done();
  end

endmodule // tw_waveform_test
